// File: common/supply_seq_pkg.sv
// Constants for the supply supervisor and output sequencer.
// Assumes a 100 MHz core clock; delays are default times in microseconds.
package supply_seq_pkg;
   localparam int CLK_PERIOD_NS          = 10;
   // Delay times in microseconds, default figures
   localparam int RESET_RELEASE_TIME_US  = 20;
   localparam int RESET_OUTPUT_DELAY_US  = 10;
   localparam int LOCKOUT_ENTRY_DELAY_US = 10;
   localparam int LOCKOUT_EXIT_DELAY_US  = 10;
   localparam int COMPENSATION_DELAY_US  = 20;
   // Least times round up to whole cycles
   localparam int RESET_RELEASE_CYC  = (RESET_RELEASE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int RESET_OUTPUT_CYC   = (RESET_OUTPUT_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int LOCKOUT_ENTRY_CYC  = (LOCKOUT_ENTRY_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int LOCKOUT_EXIT_CYC   = (LOCKOUT_EXIT_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int COMPENSATION_CYC   = (COMPENSATION_DELAY_US * 1000 + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int CNT_W              = 16;
   // Output drive codes
   localparam logic [1:0] OUT_HIZ    = 2'h0;
   localparam logic [1:0] OUT_GROUND = 2'h1;
   localparam logic [1:0] OUT_NORMAL = 2'h2;
   // Quiescent level codes: tenths of supply
   localparam logic [3:0] QUIESCENT_BIDIR  = 4'h5;
   localparam logic [3:0] QUIESCENT_UNIDIR = 4'h1;
   localparam int SYNC_STAGES = 3;
   typedef enum {ST_RESET, ST_RELEASE, ST_WAIT_EXIT, ST_EXIT_DELAY, ST_PORD,
                 ST_NORMAL, ST_ENTRY_DELAY, ST_LOCKOUT} seq_state_t;
endpackage : supply_seq_pkg

// File: rtl/flag_sync.sv
// Three-stage synchroniser for a comparator flag.
// Assumes the flag is asynchronous; output changes when stages one and two agree.
`timescale 1ns/10ps
module flag_sync
   import supply_seq_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // Flag
   input  wire logic async_in,
   output logic      sync_out
);
   logic [SYNC_STAGES-1:0] stage_ff;
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         stage_ff <= '0;
      end else begin
         stage_ff <= {stage_ff[SYNC_STAGES-2:0], async_in};
      end
   end
   // Stage zero feeds only stage one
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sync_out <= 1'b0;
      end else if (stage_ff[1] == stage_ff[2]) begin
         sync_out <= stage_ff[2];
      end
   end
endmodule : flag_sync

// File: rtl/delay_counter.sv
// Restartable down counter, reports done when it has run its full length.
// Assumes start is a one-cycle pulse from the same clock.
`timescale 1ns/10ps
module delay_counter
   import supply_seq_pkg::*;
#(
   parameter int CYCLES = 100
)(
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // Control
   input  wire logic start,
   input  wire logic abort,
   output logic      running,
   output logic      done
);
   logic [CNT_W-1:0] count_ff;
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         count_ff <= '0;
         running  <= 1'b0;
         done     <= 1'b0;
      end else if (abort) begin
         count_ff <= '0;
         running  <= 1'b0;
         done     <= 1'b0;
      end else if (start) begin
         count_ff <= CNT_W'(CYCLES - 1);
         running  <= 1'b1;
         done     <= 1'b0;
      end else if (running) begin
         if (count_ff == '0) begin
            running <= 1'b0;
            done    <= 1'b1;
         end else begin
            count_ff <= count_ff - CNT_W'(1);
         end
      end else begin
         done <= 1'b0;
      end
   end
endmodule : delay_counter

// File: rtl/por_undervoltage_lockout_output_sequencer.sv
// Supply supervisor: reset release, lockout, output state, compensation trigger.
// Assumes asynchronous comparator flags high while supply is above each threshold.
//
// Behaviour
// - Output high impedance while rising before reset release.
// - Crossing reset rise threshold starts reset release counter.
// - Release only after counter expires with supply continuously above threshold.
// - 5 V mode: normal output after exit delay above exit threshold.
// - 5 V mode: low supply past entry delay enters lockout, output near ground.
// - 5 V mode: recovery before entry delay expires keeps normal output.
// - In lockout, exit threshold plus exit delay restores normal output.
// - Below fall threshold: reset, output high impedance, even mid entry delay.
// - Two modes: 5 V with lockout, 3.3 V without.
// - 3.3 V mode: normal output after reset output delay post release.
// - Compensation update pulses after compensation delay once output released.
// - 3.3 V mode: dip above fall threshold leaves output normal.
// - Quiescent level half supply bidirectional, tenth unidirectional.
// - Clamp disable passes straight to output stage, saturation limits then.
`timescale 1ns/10ps
module por_undervoltage_lockout_output_sequencer
   import supply_seq_pkg::*;
#(
   parameter int RELEASE_CYC = RESET_RELEASE_CYC,
   parameter int PORD_CYC    = RESET_OUTPUT_CYC,
   parameter int ENTRY_CYC   = LOCKOUT_ENTRY_CYC,
   parameter int EXIT_CYC    = LOCKOUT_EXIT_CYC,
   parameter int COMP_CYC    = COMPENSATION_CYC
)(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_b,
   // Threshold comparator flags
   input  wire logic       above_reset_rise_threshold,
   input  wire logic       above_reset_fall_threshold,
   input  wire logic       above_lockout_exit_threshold,
   input  wire logic       above_lockout_entry_threshold,
   // Configuration straps
   input  wire logic       mode_5v,
   input  wire logic       unidirectional,
   input  wire logic       clamp_disable,
   // Output stage control
   output logic [1:0]      output_state,
   output logic [3:0]      quiescent_output_level,
   output logic            clamp_enable,
   output logic            undervoltage_lockout,
   output logic            reset_active,
   output logic            compensation_update
);
   logic        rise_s;
   logic        fall_s;
   logic        exit_s;
   logic        entry_s;
   logic        rise_d_ff;
   seq_state_t  state_ff;
   seq_state_t  nxt_state;
   logic        rel_start;
   logic        rel_done;
   logic        rel_run;
   logic        pord_start;
   logic        pord_done;
   logic        entry_start;
   logic        entry_done;
   logic        exit_start;
   logic        exit_done;
   logic        comp_start;
   logic        comp_done;
   logic [1:0]  nxt_output_state;

   flag_sync u_sync_rise (.clock(clock), .rst_b(rst_b),
      .async_in(above_reset_rise_threshold), .sync_out(rise_s));
   flag_sync u_sync_fall (.clock(clock), .rst_b(rst_b),
      .async_in(above_reset_fall_threshold), .sync_out(fall_s));
   flag_sync u_sync_exit (.clock(clock), .rst_b(rst_b),
      .async_in(above_lockout_exit_threshold), .sync_out(exit_s));
   flag_sync u_sync_entry (.clock(clock), .rst_b(rst_b),
      .async_in(above_lockout_entry_threshold), .sync_out(entry_s));

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rise_d_ff <= 1'b0;
      end else begin
         rise_d_ff <= rise_s;
      end
   end

   // Release, output delay and compensation counters abort on a lost supply flag; exit and entry abort only on their flag in their state
   assign rel_start   = (state_ff == ST_RESET) && rise_s && !rise_d_ff;
   assign pord_start  = (state_ff == ST_RELEASE) && rel_done && !mode_5v;
   assign exit_start  = (nxt_state == ST_EXIT_DELAY) && (state_ff != ST_EXIT_DELAY);
   assign entry_start = (nxt_state == ST_ENTRY_DELAY) && (state_ff != ST_ENTRY_DELAY);
   assign comp_start  = (nxt_state == ST_NORMAL) && (state_ff == ST_PORD
                        || state_ff == ST_EXIT_DELAY);

   delay_counter #(.CYCLES(RELEASE_CYC)) u_rel (.clock(clock), .rst_b(rst_b),
      .start(rel_start), .abort(!rise_s), .running(rel_run), .done(rel_done));
   delay_counter #(.CYCLES(PORD_CYC)) u_pord (.clock(clock), .rst_b(rst_b),
      .start(pord_start), .abort(!fall_s), .running(), .done(pord_done));
   delay_counter #(.CYCLES(EXIT_CYC)) u_exit (.clock(clock), .rst_b(rst_b),
      .start(exit_start), .abort(state_ff == ST_EXIT_DELAY && !exit_s),
      .running(), .done(exit_done));
   delay_counter #(.CYCLES(ENTRY_CYC)) u_entry (.clock(clock), .rst_b(rst_b),
      .start(entry_start), .abort(state_ff == ST_ENTRY_DELAY && entry_s),
      .running(), .done(entry_done));
   delay_counter #(.CYCLES(COMP_CYC)) u_comp (.clock(clock), .rst_b(rst_b),
      .start(comp_start), .abort(!fall_s), .running(), .done(comp_done));

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RESET: begin
            if (rel_start) begin
               nxt_state = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            if (!rise_s) begin
               nxt_state = ST_RESET;
            end else if (rel_done && mode_5v) begin
               nxt_state = exit_s ? ST_EXIT_DELAY : ST_WAIT_EXIT;
            end else if (rel_done) begin
               nxt_state = ST_PORD;
            end
         end
         ST_WAIT_EXIT: begin
            if (exit_s) begin
               nxt_state = ST_EXIT_DELAY;
            end
         end
         ST_EXIT_DELAY: begin
            if (!exit_s) begin
               // An exit cut short from lockout goes back to lockout, not high impedance
               nxt_state = (output_state == OUT_GROUND) ? ST_LOCKOUT : ST_WAIT_EXIT;
            end else if (exit_done) begin
               nxt_state = ST_NORMAL;
            end
         end
         ST_PORD: begin
            if (pord_done) begin
               nxt_state = ST_NORMAL;
            end
         end
         ST_NORMAL: begin
            // 3.3 V mode ignores the lockout comparators entirely
            if (mode_5v && !entry_s) begin
               nxt_state = ST_ENTRY_DELAY;
            end
         end
         ST_ENTRY_DELAY: begin
            if (entry_s) begin
               nxt_state = ST_NORMAL;
            end else if (entry_done) begin
               nxt_state = ST_LOCKOUT;
            end
         end
         ST_LOCKOUT: begin
            if (exit_s) begin
               nxt_state = ST_EXIT_DELAY;
            end
         end
         default: nxt_state = ST_RESET;
      endcase
      // Fall threshold overrides every state but reset and release, including a running entry delay
      if (!fall_s && state_ff != ST_RESET && state_ff != ST_RELEASE) begin
         nxt_state = ST_RESET;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_ff <= ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_comb begin
      case (nxt_state)
         ST_NORMAL, ST_ENTRY_DELAY: nxt_output_state = OUT_NORMAL;
         ST_LOCKOUT:                nxt_output_state = OUT_GROUND;
         ST_EXIT_DELAY: begin
            // Leaving lockout holds ground until the exit delay expires
            nxt_output_state = (state_ff == ST_LOCKOUT || output_state == OUT_GROUND)
                               ? OUT_GROUND : OUT_HIZ;
         end
         default:                   nxt_output_state = OUT_HIZ;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         output_state         <= OUT_HIZ;
         undervoltage_lockout <= 1'b0;
         reset_active         <= 1'b1;
      end else begin
         output_state         <= nxt_output_state;
         undervoltage_lockout <= (nxt_output_state == OUT_GROUND);
         reset_active         <= (nxt_state == ST_RESET || nxt_state == ST_RELEASE);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         compensation_update <= 1'b0;
      end else begin
         compensation_update <= comp_done;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         quiescent_output_level <= QUIESCENT_BIDIR;
         clamp_enable           <= 1'b1;
      end else begin
         quiescent_output_level <= unidirectional ? QUIESCENT_UNIDIR
                                                  : QUIESCENT_BIDIR;
         clamp_enable           <= !clamp_disable;
      end
   end

   // Checks
   sequence s_fall_low;
      !fall_s && state_ff != ST_RESET && state_ff != ST_RELEASE;
   endsequence
   property p_hiz_in_reset;
      @(posedge clock) disable iff (!rst_b)
      (state_ff == ST_RESET) |=> (output_state == OUT_HIZ);
   endproperty
   a_hiz_in_reset: assert property (p_hiz_in_reset)
      else $error("output not high impedance in reset");
   property p_rel_start;
      @(posedge clock) disable iff (!rst_b)
      (state_ff == ST_RESET && rise_s && !rise_d_ff) |=> rel_run;
   endproperty
   a_rel_start: assert property (p_rel_start)
      else $error("release counter did not start");
   property p_release_needs_rise;
      @(posedge clock) disable iff (!rst_b)
      (state_ff == ST_RELEASE && !rise_s) |=> (state_ff == ST_RESET);
   endproperty
   a_release_needs_rise: assert property (p_release_needs_rise)
      else $error("release survived supply drop");
   property p_no_normal_from_reset;
      @(posedge clock) disable iff (!rst_b)
      $rose(output_state == OUT_NORMAL)
      |-> $past(state_ff) == (mode_5v ? ST_EXIT_DELAY : ST_PORD);
   endproperty
   a_no_normal_from_reset: assert property (p_no_normal_from_reset)
      else $error("normal output straight from reset");
   property p_lockout_ground;
      @(posedge clock) disable iff (!rst_b)
      (state_ff == ST_ENTRY_DELAY && entry_done && !entry_s && fall_s)
      |=> (output_state == OUT_GROUND) && undervoltage_lockout;
   endproperty
   a_lockout_ground: assert property (p_lockout_ground)
      else $error("lockout not entered");
   property p_recover;
      @(posedge clock) disable iff (!rst_b)
      (state_ff == ST_ENTRY_DELAY && entry_s && fall_s) |=> (output_state == OUT_NORMAL);
   endproperty
   a_recover: assert property (p_recover)
      else $error("output lost on brief dip");
   property p_fall_reset;
      @(posedge clock) disable iff (!rst_b)
      s_fall_low |=> (state_ff == ST_RESET) ##0 (output_state == OUT_HIZ);
   endproperty
   a_fall_reset: assert property (p_fall_reset)
      else $error("fall threshold did not reset");
   property p_no_lockout_3v3;
      @(posedge clock) disable iff (!rst_b)
      (!mode_5v && !$past(mode_5v) && state_ff == ST_NORMAL && fall_s)
      |=> (output_state == OUT_NORMAL);
   endproperty
   a_no_lockout_3v3: assert property (p_no_lockout_3v3)
      else $error("3.3 V output disturbed");
   property p_comp;
      @(posedge clock) disable iff (!rst_b)
      comp_done |=> compensation_update;
   endproperty
   a_comp: assert property (p_comp)
      else $error("compensation update missing");
   property p_comp_single;
      @(posedge clock) disable iff (!rst_b)
      compensation_update |=> !compensation_update;
   endproperty
   a_comp_single: assert property (p_comp_single)
      else $error("compensation pulse longer than one cycle");
   property p_release_clears_reset;
      @(posedge clock) disable iff (!rst_b)
      (state_ff == ST_RELEASE && rel_done && rise_s) |=> !reset_active;
   endproperty
   a_release_clears_reset: assert property (p_release_clears_reset)
      else $error("reset held after release counter expired");
   property p_no_entry_3v3;
      @(posedge clock) disable iff (!rst_b)
      (state_ff == ST_NORMAL && !mode_5v) |=> (state_ff != ST_ENTRY_DELAY);
   endproperty
   a_no_entry_3v3: assert property (p_no_entry_3v3)
      else $error("lockout path taken in 3.3 V mode");
   // Exit flag lost during the exit delay must not leave ground for high impedance
   sequence s_exit_cut;
      state_ff == ST_EXIT_DELAY && output_state == OUT_GROUND && !exit_s && fall_s;
   endsequence
   property p_exit_cut_ground;
      @(posedge clock) disable iff (!rst_b)
      s_exit_cut |=> (state_ff == ST_LOCKOUT) && (output_state == OUT_GROUND);
   endproperty
   a_exit_cut_ground: assert property (p_exit_cut_ground)
      else $error("aborted lockout exit left ground");
endmodule : por_undervoltage_lockout_output_sequencer

// File: sim/supply_comparator_model.sv
// Supply and threshold comparator model that feeds the sequencer's flags.
// Assumes the bench sets the supply in millivolts off the clock edge.
`timescale 1ns/10ps
module supply_comparator_model #(
   parameter int FALL_MV  = 2500,
   parameter int RISE_MV  = 2800,
   parameter int ENTRY_MV = 4400,
   parameter int EXIT_MV  = 4600
)(
   // Supply level
   input  wire logic [31:0] supply_mv,
   // Comparator flags
   output logic      above_reset_rise_threshold,
   output logic      above_reset_fall_threshold,
   output logic      above_lockout_exit_threshold,
   output logic      above_lockout_entry_threshold
);
   // No hysteresis, so a dip shows on the flags exactly as long as it lasts
   assign above_reset_rise_threshold    = supply_mv > RISE_MV;
   assign above_reset_fall_threshold    = supply_mv > FALL_MV;
   assign above_lockout_exit_threshold  = supply_mv > EXIT_MV;
   assign above_lockout_entry_threshold = supply_mv > ENTRY_MV;
endmodule : supply_comparator_model

// File: sim/por_undervoltage_lockout_output_sequencer_tb.sv
// Self-checking bench for the supply sequencer, driven through a supply model.
// Assumes short delay parameters; windows allow sync and counter overhead.
`timescale 1ns/10ps
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED t=%0t %s", $time, msg); end end
module por_undervoltage_lockout_output_sequencer_tb;
   import supply_seq_pkg::*;
   localparam int REL = 8, PORD = 6, ENT = 12, EXT = 7, COMP = 9;
   logic        clock, rst_b, mode_5v, unidirectional, clamp_disable;
   logic        rise_f, fall_f, exit_f, entry_f, saw_ground;
   logic [1:0]  output_state;
   logic [3:0]  quiescent_output_level;
   logic        clamp_enable, undervoltage_lockout, reset_active, compensation_update;
   logic [31:0] lfsr;
   int          supply_mv, err_count, n_checks, d;

   supply_comparator_model i_supply (
      .supply_mv(supply_mv), .above_reset_rise_threshold(rise_f),
      .above_reset_fall_threshold(fall_f), .above_lockout_exit_threshold(exit_f),
      .above_lockout_entry_threshold(entry_f));

   por_undervoltage_lockout_output_sequencer #(.RELEASE_CYC(REL), .PORD_CYC(PORD), .ENTRY_CYC(ENT),
      .EXIT_CYC(EXT), .COMP_CYC(COMP)) i_dut (
      .clock(clock), .rst_b(rst_b), .above_reset_rise_threshold(rise_f),
      .above_reset_fall_threshold(fall_f), .above_lockout_exit_threshold(exit_f),
      .above_lockout_entry_threshold(entry_f), .mode_5v(mode_5v),
      .unidirectional(unidirectional), .clamp_disable(clamp_disable),
      .output_state(output_state), .quiescent_output_level(quiescent_output_level),
      .clamp_enable(clamp_enable), .undervoltage_lockout(undervoltage_lockout),
      .reset_active(reset_active), .compensation_update(compensation_update));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   always @(negedge clock) if (output_state === OUT_GROUND) saw_ground <= 1'b1;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   function automatic logic [3:0] exp_level(input logic uni);
      return uni ? QUIESCENT_UNIDIR : QUIESCENT_BIDIR;
   endfunction : exp_level

   task automatic wrap_up();
      if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : wrap_up

   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask : cyc

   task automatic do_reset(input logic m5);
      rst_b = 1'b0;
      mode_5v = m5;
      supply_mv = 0;
      cyc(12);
      `CHK(output_state, OUT_HIZ, "output not high impedance in reset")
      `CHK(reset_active, 1'b1, "reset not active in reset")
      `CHK({undervoltage_lockout, compensation_update}, 2'h0, "lockout or update in reset")
      rst_b = 1'b1;
   endtask : do_reset

   // Waits for a state and checks it arrived inside the window
   task automatic expect_state(input logic [1:0] exp, input int lo, input int hi);
      int n;
      n = 0;
      while (output_state !== exp && n < hi) begin
         @(negedge clock);
         n++;
      end
      `CHK(output_state, exp, "output state not reached in time")
      `CHK(n >= lo, 1'b1, "output state reached too early")
   endtask : expect_state

   task automatic hold(input logic [1:0] exp, input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(negedge clock);
         if (output_state !== exp) bad = 1'b1;
      end
      `CHK(bad, 1'b0, "output state did not hold")
   endtask : hold

   task automatic expect_comp(input int lo, input int hi);
      int n;
      n = 0;
      while (compensation_update !== 1'b1 && n < hi) begin
         @(negedge clock);
         n++;
      end
      `CHK(compensation_update, 1'b1, "no compensation update")
      `CHK(n >= lo, 1'b1, "compensation update too early")
      cyc(1);
      `CHK(compensation_update, 1'b0, "compensation update wider than one cycle")
   endtask : expect_comp

   initial begin
      #(20000 * 10);
      err_count++;
      wrap_up();
   end

   initial begin
      err_count = 0;
      n_checks = 0;
      lfsr = 32'h0001_6918;
      saw_ground = 1'b0;
      unidirectional = 1'b0;
      clamp_disable = 1'b0;
      do_reset(1'b1);
      `CHK({quiescent_output_level, clamp_enable}, {QUIESCENT_BIDIR, 1'b1}, "reset straps")
      supply_mv = 5000;
      hold(OUT_HIZ, REL);
      expect_state(OUT_NORMAL, EXT - 2, EXT + 16);
      `CHK(reset_active, 1'b0, "reset still active after release")
      expect_comp(COMP - 2, COMP + 8);
      for (int i = 0; i < 3; i++) begin
         lfsr = lfsr_next(lfsr);
         d = 1 + int'(lfsr[3:0]) % (ENT / 2);
         supply_mv = 4000;
         cyc(d);
         supply_mv = 5000;
         hold(OUT_NORMAL, ENT + 8);
      end
      supply_mv = 4000;
      expect_state(OUT_GROUND, ENT - 2, ENT + 10);
      `CHK(undervoltage_lockout, 1'b1, "lockout flag not set")
      supply_mv = 4500;
      hold(OUT_GROUND, EXT + 8);
      // Exit threshold seen for less than the exit delay: lockout stays
      supply_mv = 5000;
      cyc(EXT - 2);
      supply_mv = 4500;
      hold(OUT_GROUND, EXT + 8);
      supply_mv = 5000;
      expect_state(OUT_NORMAL, EXT - 2, EXT + 10);
      `CHK(undervoltage_lockout, 1'b0, "lockout flag not cleared")
      supply_mv = 4000;
      cyc(2);
      saw_ground = 1'b0;
      supply_mv = 1000;
      expect_state(OUT_HIZ, 0, 10);
      `CHK({saw_ground, reset_active}, 2'h1, "fall mid entry not straight to reset")
      supply_mv = 5000;
      cyc(REL / 2);
      supply_mv = 2700;
      cyc(4);
      supply_mv = 5000;
      expect_state(OUT_NORMAL, REL + EXT - 2, REL + EXT + 16);
      supply_mv = 4000;
      expect_state(OUT_GROUND, ENT - 2, ENT + 10);
      supply_mv = 1000;
      expect_state(OUT_HIZ, 0, 10);
      supply_mv = 3000;
      hold(OUT_HIZ, REL + EXT + 10);
      supply_mv = 5000;
      expect_state(OUT_NORMAL, EXT - 2, EXT + 10);
      do_reset(1'b0);
      supply_mv = 3300;
      expect_state(OUT_NORMAL, REL + PORD - 2, REL + PORD + 16);
      expect_comp(COMP - 2, COMP + 8);
      supply_mv = 2700;
      hold(OUT_NORMAL, ENT + 8);
      `CHK(undervoltage_lockout, 1'b0, "lockout in low supply mode")
      supply_mv = 1000;
      expect_state(OUT_HIZ, 0, 10);
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         unidirectional = lfsr[0];
         clamp_disable = lfsr[1];
         cyc(2);
         `CHK(quiescent_output_level, exp_level(lfsr[0]), "quiescent level wrong")
         `CHK(clamp_enable, ~lfsr[1], "clamp enable wrong")
      end
      wrap_up();
   end
endmodule : por_undervoltage_lockout_output_sequencer_tb
